// ### hdl/dac_host_defs.svh
// Constants for the dual DAC parallel-bus host controller
// Contract
// - A write needs chip select and write strobe low together; alone neither writes.
// - Channel select picks channel A or B input register for the write.
// - Wide variant: twelve data bits in one write, bit 11 most significant.
// - Byte variant: eight data bits, bit 7 most significant.
// - Byte variant: upper byte select level picks high or low byte register.
`ifndef DAC_HOST_DEFS_SVH
`define DAC_HOST_DEFS_SVH
// Host register offsets (word index = byte address / 4)
`define REG_CTRL 4'h0
`define REG_CODE_A 4'h1
`define REG_CODE_B 4'h2
`define REG_CMD 4'h3
`define REG_STATUS 4'h4
// Control register fields
`define CTRL_GAIN_BIT 0
`define CTRL_BUF_BIT 1
`define CTRL_PD_BIT 2
`define CTRL_BYTE_MODE_BIT 3
`define CTRL_RESET 4'h0
// Command register fields
`define CMD_WRITE_A_BIT 0
`define CMD_WRITE_B_BIT 1
`define CMD_UPDATE_BIT 2
`define CMD_CLEAR_BIT 3
// Status register fields
`define STAT_BUSY_BIT 0
// Bus phase lengths in clock cycles (20 ns each)
`define SETUP_CYCLES 4'h2
`define STROBE_CYCLES 4'h3
`define HOLD_CYCLES 4'h2
`define PULSE_CYCLES 4'h3
`define CODE_MAX 12'hfff
`endif

// ### hdl/dac_host_pkg.sv
// Types for the dual DAC parallel-bus host controller
package dac_host_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_STROBE = 6'b000100,
    ST_HOLD = 6'b001000,
    ST_PULSE = 6'b010000,
    ST_NEXT = 6'b100000
  } phase_t;
  typedef logic [3:0] addr_t;
  typedef logic [31:0] word_t;
  typedef logic [11:0] code_t;
endpackage

// ### hdl/phase_timer.sv
// Down counter that times each bus phase
`timescale 1ns/1ps
`default_nettype none
module phase_timer #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } timer_state_t;
  timer_state_t s_r;
  timer_state_t s_nxt;

  // Load wins over counting so a new phase always starts fresh
  always_comb
  begin
    s_nxt = s_r;
    if (load)
      s_nxt.cnt = count;
    else if (s_r.cnt != '0)
      s_nxt.cnt = s_r.cnt - {{(W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '0;
    else if (ce)
      s_r <= s_nxt;
  end

  assign done = (s_r.cnt == {{(W-1){1'b0}}, 1'b1}) || (s_r.cnt == '0);
endmodule // phase_timer
`default_nettype wire

// ### hdl/dac_host.sv
// Host controller driving the dual DAC parallel write bus and control pins
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dac_host_defs.svh"
module dac_host (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire dac_host_pkg::addr_t addr,
  input wire dac_host_pkg::word_t wdata,
  input wire logic wr,
  input wire logic rd,
  output dac_host_pkg::word_t rdata,
  output logic chip_select_n,
  output logic write_n,
  output logic channel_select,
  output logic upper_byte_select,
  output logic [11:0] parallel_data_in,
  output logic clear_all_n,
  output logic output_update_n,
  output logic power_down_n,
  output logic gain_select,
  output logic ref_buffer_select
);
  import dac_host_pkg::*;

  typedef struct packed {
    word_t rdata;
    logic [3:0] ctrl;
    code_t code_a;
    code_t code_b;
    logic pend_a;
    logic pend_b;
    logic pend_upd;
    logic pend_clr;
    phase_t phase;
    logic chan;
    logic hi_byte;
    logic is_clear;
    logic cs_n;
    logic wr_n;
    logic sel;
    logic ube;
    code_t data;
    logic clr_n;
    logic upd_n;
    logic pd_n;
  } host_state_t;

  host_state_t s_r;
  host_state_t s_nxt;
  logic rst_sync_b;
  logic rst_meta_r;
  logic rst_sync_r;
  logic tmr_load;
  logic [3:0] tmr_count;
  logic tmr_done;
  code_t cur_code;

  // Reset released through two flops; the first one feeds only the second
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_sync_b = rst_sync_r;

  phase_timer #(.W(4)) u_timer (
    .clk(clk),
    .rst_b(rst_sync_b),
    .ce(ce),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  assign cur_code = s_r.chan ? s_r.code_b : s_r.code_a;

  // Register port, command queue and pin sequencer
  always_comb
  begin
    s_nxt = s_r;
    tmr_load = 1'b0;
    tmr_count = `SETUP_CYCLES;
    s_nxt.rdata = '0;
    if (rd)
    begin
      case (addr)
        `REG_CTRL: s_nxt.rdata = {28'h0000000, s_r.ctrl};
        `REG_CODE_A: s_nxt.rdata = {20'h00000, s_r.code_a};
        `REG_CODE_B: s_nxt.rdata = {20'h00000, s_r.code_b};
        `REG_STATUS: s_nxt.rdata = {27'h0000000, s_r.pend_clr,
          s_r.pend_upd, s_r.pend_b, s_r.pend_a,
          s_r.phase != ST_IDLE};
        default: s_nxt.rdata = '0;
      endcase
    end
    if (wr)
    begin
      case (addr)
        `REG_CTRL: s_nxt.ctrl = wdata[3:0];
        `REG_CODE_A: s_nxt.code_a = wdata[11:0]; // Straight binary
        `REG_CODE_B: s_nxt.code_b = wdata[11:0];
        `REG_CMD:
        begin
          // Set wins over the clear done when the sequencer takes it
          if (wdata[`CMD_WRITE_A_BIT]) s_nxt.pend_a = 1'b1;
          if (wdata[`CMD_WRITE_B_BIT]) s_nxt.pend_b = 1'b1;
          if (wdata[`CMD_UPDATE_BIT]) s_nxt.pend_upd = 1'b1;
          if (wdata[`CMD_CLEAR_BIT]) s_nxt.pend_clr = 1'b1;
        end
        default: ;
      endcase
    end
    // Registered so the pin comes straight from a flop
    s_nxt.pd_n = !s_nxt.ctrl[`CTRL_PD_BIT]; // Both channels
    case (s_r.phase)
      ST_IDLE:
      begin
        // Clear first, then channel writes, then the update pulse
        if (s_r.pend_clr)
        begin
          s_nxt.pend_clr = wr && addr == `REG_CMD && wdata[`CMD_CLEAR_BIT];
          s_nxt.is_clear = 1'b1;
          s_nxt.clr_n = 1'b0; // Clears every register in the DAC
          tmr_load = 1'b1;
          tmr_count = `PULSE_CYCLES;
          s_nxt.phase = ST_PULSE;
        end
        else if (s_r.pend_a || s_r.pend_b)
        begin
          s_nxt.chan = !s_r.pend_a;
          if (s_r.pend_a)
            s_nxt.pend_a = wr && addr == `REG_CMD && wdata[`CMD_WRITE_A_BIT];
          else
            s_nxt.pend_b = wr && addr == `REG_CMD && wdata[`CMD_WRITE_B_BIT];
          s_nxt.hi_byte = 1'b1;
          tmr_load = 1'b1;
          s_nxt.phase = ST_SETUP;
        end
        else if (s_r.pend_upd)
        begin
          s_nxt.pend_upd = wr && addr == `REG_CMD && wdata[`CMD_UPDATE_BIT];
          s_nxt.is_clear = 1'b0;
          s_nxt.upd_n = 1'b0; // Both DAC registers load together
          tmr_load = 1'b1;
          tmr_count = `PULSE_CYCLES;
          s_nxt.phase = ST_PULSE;
        end
      end
      ST_SETUP:
      begin
        // Address, data and byte select settle before the strobe
        s_nxt.sel = s_r.chan; // Channel routing
        s_nxt.cs_n = 1'b0;
        if (s_r.ctrl[`CTRL_BYTE_MODE_BIT])
        begin
          s_nxt.ube = s_r.hi_byte; // Byte register select
          s_nxt.data = s_r.hi_byte ? {4'h0, 4'h0, cur_code[11:8]} :
            {4'h0, cur_code[7:0]}; // Bit 7 is the byte MSB
        end
        else
        begin
          s_nxt.ube = 1'b0;
          s_nxt.data = cur_code; // Whole code, bit 11 MSB
        end
        if (tmr_done)
        begin
          s_nxt.wr_n = 1'b0; // Strobe only with chip select low
          tmr_load = 1'b1;
          tmr_count = `STROBE_CYCLES;
          s_nxt.phase = ST_STROBE;
        end
      end
      ST_STROBE:
      begin
        if (tmr_done)
        begin
          s_nxt.wr_n = 1'b1; // Rising edge latches the data
          tmr_load = 1'b1;
          tmr_count = `HOLD_CYCLES;
          s_nxt.phase = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        // Data and chip select held past the rising edge
        if (tmr_done)
        begin
          s_nxt.cs_n = 1'b1;
          s_nxt.phase = ST_NEXT;
        end
      end
      ST_NEXT:
      begin
        // Byte mode needs a second, low byte write
        if (s_r.ctrl[`CTRL_BYTE_MODE_BIT] && s_r.hi_byte)
        begin
          s_nxt.hi_byte = 1'b0;
          tmr_load = 1'b1;
          s_nxt.phase = ST_SETUP;
        end
        else
          s_nxt.phase = ST_IDLE;
      end
      ST_PULSE:
      begin
        if (tmr_done)
        begin
          s_nxt.clr_n = 1'b1;
          s_nxt.upd_n = 1'b1; // High again so DAC registers hold
          s_nxt.phase = ST_IDLE;
        end
      end
      default: s_nxt.phase = ST_IDLE;
    endcase
  end

  // State register; the sync flops are written in their own process
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      s_r.rdata <= '0;
      s_r.ctrl <= `CTRL_RESET;
      s_r.code_a <= '0;
      s_r.code_b <= '0;
      s_r.pend_a <= 1'b0;
      s_r.pend_b <= 1'b0;
      s_r.pend_upd <= 1'b0;
      s_r.pend_clr <= 1'b0;
      s_r.phase <= ST_IDLE;
      s_r.chan <= 1'b0;
      s_r.hi_byte <= 1'b0;
      s_r.is_clear <= 1'b0;
      s_r.cs_n <= 1'b1;
      s_r.wr_n <= 1'b1;
      s_r.sel <= 1'b0;
      s_r.ube <= 1'b0;
      s_r.data <= '0;
      s_r.clr_n <= 1'b1;
      s_r.upd_n <= 1'b1;
      s_r.pd_n <= 1'b1;
    end
    else if (ce)
    begin
      s_r.rdata <= s_nxt.rdata;
      s_r.ctrl <= s_nxt.ctrl;
      s_r.code_a <= s_nxt.code_a;
      s_r.code_b <= s_nxt.code_b;
      s_r.pend_a <= s_nxt.pend_a;
      s_r.pend_b <= s_nxt.pend_b;
      s_r.pend_upd <= s_nxt.pend_upd;
      s_r.pend_clr <= s_nxt.pend_clr;
      s_r.phase <= s_nxt.phase;
      s_r.chan <= s_nxt.chan;
      s_r.hi_byte <= s_nxt.hi_byte;
      s_r.is_clear <= s_nxt.is_clear;
      s_r.cs_n <= s_nxt.cs_n;
      s_r.wr_n <= s_nxt.wr_n;
      s_r.sel <= s_nxt.sel;
      s_r.ube <= s_nxt.ube;
      s_r.data <= s_nxt.data;
      s_r.clr_n <= s_nxt.clr_n;
      s_r.upd_n <= s_nxt.upd_n;
      s_r.pd_n <= s_nxt.pd_n;
    end
  end

  // Pins come straight from flops
  assign rdata = s_r.rdata;
  assign chip_select_n = s_r.cs_n;
  assign write_n = s_r.wr_n;
  assign channel_select = s_r.sel;
  assign upper_byte_select = s_r.ube;
  assign parallel_data_in = s_r.data;
  assign clear_all_n = s_r.clr_n;
  assign output_update_n = s_r.upd_n;
  assign power_down_n = s_r.pd_n; // Both channels
  assign gain_select = s_r.ctrl[`CTRL_GAIN_BIT]; // Static level
  assign ref_buffer_select = s_r.ctrl[`CTRL_BUF_BIT]; // Static
endmodule // dac_host
`default_nettype wire

// ### verif/dac_host_props.sv
// Checker for the DAC host bus and control pin timing
`timescale 1ns/1ps
`default_nettype none
`include "dac_host_defs.svh"
module dac_host_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire dac_host_pkg::addr_t addr,
  input wire dac_host_pkg::word_t wdata,
  input wire logic wr,
  input wire logic chip_select_n,
  input wire logic write_n,
  input wire logic channel_select,
  input wire logic upper_byte_select,
  input wire logic [11:0] parallel_data_in,
  input wire logic clear_all_n,
  input wire logic output_update_n,
  input wire logic power_down_n,
  input wire logic gain_select,
  input wire logic ref_buffer_select
);
  import dac_host_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Control register bits reach the static pins one cycle on; checked two cycles on
  property p_ctrl_pins;
    logic [3:0] v;
    (wr && ce && addr == `REG_CTRL, v = wdata[3:0]) |-> ##2
      (gain_select == v[0] && ref_buffer_select == v[1]
       && power_down_n == !v[2]);
  endproperty
  a_write_in_select: assert property (
    $fell(write_n) |-> !chip_select_n)
    else $error("write strobe without chip select");
  a_select_leads: assert property (
    $fell(chip_select_n) |=> $fell(write_n))
    else $error("write strobe does not follow select");
  a_strobe_width: assert property (
    $fell(write_n) |-> !write_n[*3] ##1 write_n)
    else $error("write strobe width wrong");
  a_select_hold: assert property (
    $rose(write_n) |-> !chip_select_n[*2] ##1 chip_select_n)
    else $error("chip select hold wrong");
  a_bus_stable: assert property (
    !chip_select_n && $past(!chip_select_n) |-> $stable(parallel_data_in)
      && $stable(channel_select) && $stable(upper_byte_select))
    else $error("bus moved while selected");
  a_update_width: assert property (
    $fell(output_update_n) |-> !output_update_n[*3] ##1 output_update_n)
    else $error("update pulse width wrong");
  a_clear_width: assert property (
    $fell(clear_all_n) |-> !clear_all_n[*3] ##1 clear_all_n)
    else $error("clear pulse width wrong");
  a_upper_nibble: assert property (
    upper_byte_select |-> parallel_data_in[11:4] == 8'h00)
    else $error("upper byte carries stray bits");
  a_static_pins: assert property (p_ctrl_pins)
    else $error("static pins disagree with control");
  // Main scenarios
  c_update: cover property ($fell(output_update_n));
  c_clear: cover property ($fell(clear_all_n));
  c_high_byte: cover property ($fell(write_n) && upper_byte_select);
endmodule // dac_host_props
bind dac_host dac_host_props u_props (.clk(clk), .rst_b(rst_b), .ce(ce),
  .addr(addr), .wdata(wdata), .wr(wr), .chip_select_n(chip_select_n),
  .write_n(write_n), .channel_select(channel_select),
  .upper_byte_select(upper_byte_select),
  .parallel_data_in(parallel_data_in), .clear_all_n(clear_all_n),
  .output_update_n(output_update_n), .power_down_n(power_down_n),
  .gain_select(gain_select), .ref_buffer_select(ref_buffer_select));
`default_nettype wire

// ### verif/dac_model.sv
// Behavioural model of the dual DAC input logic
`timescale 1ns/1ps
`default_nettype none
module dac_model (
  input wire logic byte_mode,
  input wire logic chip_select_n,
  input wire logic write_n,
  input wire logic channel_select,
  input wire logic upper_byte_select,
  input wire logic [11:0] parallel_data_in,
  input wire logic clear_all_n,
  input wire logic output_update_n,
  input wire logic power_down_n,
  input wire logic gain_select,
  input wire logic ref_buffer_select,
  output logic [11:0] in_a,
  output logic [11:0] in_b,
  output logic [11:0] dac_a,
  output logic [11:0] dac_b,
  output logic powered_down,
  output logic span_double,
  output logic ref_buffered
);
  logic [11:0] nv;
  // Power-on state is code zero, straight binary
  initial
  begin
    in_a = '0;
    in_b = '0;
    dac_a = '0;
    dac_b = '0;
  end
  // Static pins, one power-down for both channels
  assign powered_down = !power_down_n;
  assign span_double = gain_select;
  assign ref_buffered = ref_buffer_select;
  // Latch on strobe rise while selected
  always @(posedge write_n)
    if (!chip_select_n && clear_all_n)
    begin
      nv = channel_select ? in_b : in_a;
      if (!byte_mode)
        nv = parallel_data_in;
      else if (upper_byte_select)
        nv[11:8] = parallel_data_in[3:0];
      else
        nv[7:0] = parallel_data_in[7:0];
      if (channel_select)
        in_b = nv;
      else
        in_a = nv;
    end
  // Both channels move together; held while update is high
  always @(negedge output_update_n)
    if (clear_all_n)
    begin
      dac_a = in_a;
      dac_b = in_b;
    end
  // Clear overrides everything
  always @(negedge clear_all_n)
  begin
    in_a = '0;
    in_b = '0;
    dac_a = '0;
    dac_b = '0;
  end
endmodule // dac_model
`default_nettype wire

// ### verif/dac_host_tb_top.sv
// Self-checking bench for the dual DAC host controller
`timescale 1ns/1ps
`default_nettype none
`include "dac_host_defs.svh"
module dac_host_tb_top;
  import dac_host_pkg::*;
  logic clk, rst_b, ce, wr, rd, byte_mode;
  addr_t addr;
  word_t wdata, rdata, rv;
  logic cs_n, wr_n, ch, ube, clr_n, upd_n, pd_n, gain, bsel, pdn, span, rbuf;
  logic [11:0] data, in_a, in_b, dac_a, dac_b;
  int miscompares, check_count, ea, eb, da, db, n;
  int codes[$];
  dac_host uut (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .chip_select_n(cs_n),
    .write_n(wr_n), .channel_select(ch), .upper_byte_select(ube),
    .parallel_data_in(data), .clear_all_n(clr_n), .output_update_n(upd_n),
    .power_down_n(pd_n), .gain_select(gain), .ref_buffer_select(bsel));
  dac_model dev (.byte_mode(byte_mode), .chip_select_n(cs_n),
    .write_n(wr_n), .channel_select(ch), .upper_byte_select(ube),
    .parallel_data_in(data), .clear_all_n(clr_n), .output_update_n(upd_n),
    .power_down_n(pd_n), .gain_select(gain), .ref_buffer_select(bsel),
    .in_a(in_a), .in_b(in_b), .dac_a(dac_a), .dac_b(dac_b),
    .powered_down(pdn), .span_double(span), .ref_buffered(rbuf));
  // Free-running clock
  always #10 clk = ~clk;
  task automatic wrap_up();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input word_t seen, input word_t exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input addr_t a, input word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rreg(input addr_t a, output word_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Issue a command, then poll status with a bounded count
  task automatic cmd(input logic [3:0] c);
    wreg(`REG_CMD, {28'h0, c});
    n = 0;
    rv = 32'h1;
    while (rv[4:0] != 5'h0 && n < 100)
    begin
      rreg(`REG_STATUS, rv);
      n++;
    end
    if (rv[4:0] !== 5'h0)
    begin
      miscompares++;
      wrap_up();
    end
  endtask
  initial
  begin
    clk = 0;
    rst_b = 0;
    ce = 1;
    wr = 0;
    rd = 0;
    addr = '0;
    wdata = '0;
    byte_mode = 0;
    n = $urandom(63790);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({27'h0, cs_n, wr_n, clr_n, upd_n, pd_n}, 32'h1f);
    rreg(`REG_CTRL, rv);
    chk(rv, 32'h0);
    // Clock enable low must swallow a control write
    @(posedge clk);
    ce <= 1'b0;
    wreg(`REG_CTRL, 32'h7);
    @(posedge clk);
    ce <= 1'b1;
    rreg(`REG_CTRL, rv);
    chk(rv, 32'h0);
    #1 chk({31'h0, pd_n}, 32'h1);
    wreg(4'h9, 32'hffffffff);
    rreg(4'h9, rv);
    chk(rv, 32'h0);
    $display("test reset done");
    // Every static pin setting
    for (int i = 0; i < 8; i++)
    begin
      wreg(`REG_CTRL, i);
      repeat (3) @(posedge clk);
      #1 chk({29'h0, pdn, rbuf, span}, i);
    end
    $display("test static pins done");
    for (int k = 0; k < 8; k++)
      codes.push_back(k == 0 ? `CODE_MAX : $urandom % 4096);
    // Wide then byte-wide transfers, update held back
    for (int k = 0; k < 2; k++)
    begin
      byte_mode = k[0];
      wreg(`REG_CTRL, k << 3);
      repeat (2)
      begin
        ea = codes.pop_front();
        eb = codes.pop_front();
        wreg(`REG_CODE_A, ea);
        wreg(`REG_CODE_B, eb);
        cmd(4'h3);
        chk(in_a, ea);
        chk(in_b, eb);
        chk(dac_a, da);
        chk(dac_b, db);
        cmd(4'h4);
        da = ea;
        db = eb;
        chk(dac_a, da);
        chk(dac_b, db);
      end
    end
    $display("test transfers done");
    // One channel written, then update in the same command
    ea = $urandom % 4096;
    wreg(`REG_CODE_A, ea);
    cmd(4'h5);
    chk(in_b, eb);
    chk(dac_a, ea);
    chk(dac_b, db);
    $display("test single channel done");
    cmd(4'h8);
    chk({8'h0, in_a, in_b}, 32'h0);
    chk({8'h0, dac_a, dac_b}, 32'h0);
    $display("test clear done");
    wrap_up();
  end
endmodule // dac_host_tb_top
`default_nettype wire
